// [verilog/sdd_core.sv]
/*
  Digital core of a two-channel sigma-delta converter: strobe generation,
  sinc3 decimation, calibration sequencing, standby and register port.
  Assumes the modulator bit arrives asynchronously and a host drives the
  register port on ref_clk.
*/
`timescale 1ns/1ps
`include "sdd_params.svh"

module sdd_core #(
  parameter int ACC_W = 36,
  parameter int BG_GAP = 16
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [`SDD_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic mod_bit_pin,
  output logic mod_strobe,
  output logic samp_strobe,
  output logic chan_sel,
  output logic [2:0] gain_code,
  output logic [1:0] cal_input_sel,
  output logic standby_out,
  output logic result_strobe
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  if (ACC_W < 36) begin : g_chk_acc
    $error("ACC_W too narrow for the longest decimation");
  end
  if (BG_GAP < 1 || BG_GAP > 255) begin : g_chk_gap
    $error("BG_GAP out of range");
  end
  if (`SDD_MOD_DIV != (1 << `SDD_CNT_W)) begin : g_chk_div
    $error("Divider width does not match modulator division");
  end

  sdd_pkg::sdd_ctrl_type ctrl;
  sdd_pkg::sdd_cal_type cal_state;
  logic [`SDD_CNT_W-1:0] div_cnt;
  logic mb_s1, mb_s2;
  logic [11:0] dec_cnt;
  logic dec_q, raw_v, res_v;
  logic signed [ACC_W-1:0] integ [0:2];
  logic signed [ACC_W-1:0] dly [0:2];
  logic signed [ACC_W-1:0] comb [0:2];
  logic signed [ACC_W-1:0] raw;
  logic signed [ACC_W-1:0] off_coef;
  logic [31:0] gain_coef;
  logic [ACC_W-1:0] span;
  logic [ACC_W:0] rem;
  logic [45:0] quo;
  logic [5:0] div_n;
  logic [7:0] gap_cnt;
  logic [2:0] settle_cnt;
  logic settle_skip;
  logic [23:0] result;
  logic data_ready;

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire wr_ctrl = reg_wr && reg_addr == `SDD_ADDR_CTRL;
  wire wr_off = reg_wr && reg_addr == `SDD_ADDR_OFFSET;
  wire wr_gain = reg_wr && reg_addr == `SDD_ADDR_GAIN;
  wire rd_data = reg_rd && reg_addr == `SDD_ADDR_DATA;
  wire sdd_pkg::sdd_ctrl_type wctrl = sdd_pkg::sdd_ctrl_type'(reg_wdata[`SDD_CTRL_W-1:0]);
  wire cal_start = wr_ctrl && wctrl.cal_mode != `SDD_CALM_NONE;
  // A control write that changes channel, gain, notch or standby restarts the settling count
  wire input_change = wr_ctrl && (wctrl.chan != ctrl.chan || wctrl.gain != ctrl.gain
                      || wctrl.notch != ctrl.notch || wctrl.standby != ctrl.standby);
  wire settled = settle_cnt == `SDD_SETTLE_PERIODS;
  wire converting = cal_state == sdd_pkg::CAL_IDLE || cal_state == sdd_pkg::CAL_GAP;

  // ****************************************************************
  // Strobes
  // ****************************************************************
  wire mod_tick = !ctrl.standby && div_cnt == '0;
  wire [2:0] samp_sh = (ctrl.gain > `SDD_SAMP_MAX_SH) ? `SDD_SAMP_MAX_SH : ctrl.gain;
  wire [7:0] samp_mask = 8'(`SDD_SAMP_DIV - 1) >> samp_sh;
  // Sub-sampling inside the modulator cycle keeps the modulator rate fixed
  wire samp_tick = !ctrl.standby && (div_cnt[7:0] & samp_mask) == 8'h00;

  always_ff @(posedge ref_clk) begin
    if (srst || ctrl.standby) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  wire done_once = cal_state == sdd_pkg::CAL_DIV && div_n == '0
                   && ctrl.cal_mode != `SDD_CALM_BG;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl <= '{standby: 1'b0, cal_mode: `SDD_CALM_NONE, chan: 1'b0, gain: 3'h0,
                notch: `SDD_NOTCH_DEF};
    end else if (wr_ctrl) begin
      ctrl <= wctrl;
    end else if (done_once) begin
      ctrl.cal_mode <= `SDD_CALM_NONE;
    end
  end

  // ****************************************************************
  // Decimation counter
  // ****************************************************************
  wire [11:0] notch_eff = (ctrl.notch < `SDD_NOTCH_MIN) ? `SDD_NOTCH_MIN :
                          (ctrl.notch > `SDD_NOTCH_MAX) ? `SDD_NOTCH_MAX : ctrl.notch;
  wire dec_edge = mod_tick && dec_cnt >= notch_eff - 12'h001;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dec_cnt <= '0;
      dec_q <= 1'b0;
      raw_v <= 1'b0;
      res_v <= 1'b0;
    end else begin
      if (mod_tick) begin
        dec_cnt <= dec_edge ? 12'h000 : dec_cnt + 12'h001;
      end
      dec_q <= dec_edge;
      raw_v <= dec_q;
      res_v <= raw_v;
    end
  end

  // ****************************************************************
  // Sinc3 filter
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    mb_s1 <= mod_bit_pin;
    mb_s2 <= mb_s1;
  end

  // Ones map to +1 and zeros to -1, so half density sums to zero
  wire signed [ACC_W-1:0] x_in = mb_s2 ? ACC_W'(1) : -ACC_W'(1);

  for (genvar k = 0; k < 3; k++) begin : g_stage
    wire signed [ACC_W-1:0] i_in;
    wire signed [ACC_W-1:0] c_in;
    if (k == 0) begin : g_first
      assign i_in = x_in;
      assign c_in = integ[2];
    end else begin : g_next
      assign i_in = integ[k-1];
      assign c_in = comb[k-1];
    end
    assign comb[k] = c_in - dly[k];
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        integ[k] <= '0;
        dly[k] <= '0;
      end else begin
        if (mod_tick) begin
          integ[k] <= integ[k] + i_in;
        end
        if (dec_q) begin
          dly[k] <= c_in;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      raw <= '0;
    end else if (dec_q) begin
      raw <= comb[2];
    end
  end

  // ****************************************************************
  // Settling
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (srst || input_change || cal_start) begin
      settle_cnt <= '0;
      settle_skip <= 1'b1;
    end else if (cal_state == sdd_pkg::CAL_ZERO && raw_v && settled) begin
      settle_cnt <= '0;
    end else if (raw_v && settle_skip) begin
      // The period in flight at a change is partial, so it does not count
      settle_skip <= 1'b0;
    end else if (raw_v && !settled) begin
      settle_cnt <= settle_cnt + 3'h1;
    end
  end

  // ****************************************************************
  // Calibration sequencer
  // ****************************************************************
  wire [ACC_W:0] trial = {rem[ACC_W-1:0], quo[45]};
  wire trial_ge = trial >= {1'b0, span};
  wire signed [ACC_W-1:0] span_raw = raw - off_coef;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cal_state <= sdd_pkg::CAL_IDLE;
      off_coef <= '0;
      gain_coef <= `SDD_GAIN_UNIT;
      span <= '0;
      rem <= '0;
      quo <= '0;
      div_n <= '0;
      gap_cnt <= '0;
    end else if (cal_start) begin
      cal_state <= sdd_pkg::CAL_ZERO;
    end else begin
      case (cal_state)
        sdd_pkg::CAL_ZERO: begin
          if (raw_v && settled) begin
            off_coef <= raw;
            cal_state <= sdd_pkg::CAL_FULL;
          end
        end
        sdd_pkg::CAL_FULL: begin
          if (raw_v && settled) begin
            span <= span_raw[ACC_W-1] ? '0 : span_raw;
            rem <= '0;
            quo <= `SDD_CAL_DIVIDEND;
            div_n <= `SDD_DIV_STEPS;
            cal_state <= sdd_pkg::CAL_DIV;
          end
        end
        sdd_pkg::CAL_DIV: begin
          if (div_n != '0) begin
            rem <= trial_ge ? trial - {1'b0, span} : trial;
            quo <= {quo[44:0], trial_ge};
            div_n <= div_n - 6'h01;
          end else begin
            // A zero span or a huge quotient means a degenerate span: saturate
            gain_coef <= (span == '0 || quo[45:32] != '0) ? 32'hffff_ffff : quo[31:0];
            gap_cnt <= '0;
            cal_state <= (ctrl.cal_mode == `SDD_CALM_BG) ? sdd_pkg::CAL_GAP
                         : sdd_pkg::CAL_IDLE;
          end
        end
        sdd_pkg::CAL_GAP: begin
          if (raw_v) begin
            gap_cnt <= gap_cnt + 8'h01;
            if (gap_cnt == 8'(BG_GAP - 1)) begin
              cal_state <= sdd_pkg::CAL_ZERO;
            end
          end
        end
        default: begin
          cal_state <= sdd_pkg::CAL_IDLE;
        end
      endcase
      if (wr_off) begin
        off_coef <= ACC_W'($signed(reg_wdata));
      end
      if (wr_gain) begin
        gain_coef <= reg_wdata;
      end
    end
  end

  // ****************************************************************
  // Output scaling and result register
  // ****************************************************************
  wire signed [ACC_W:0] diff = (ACC_W + 1)'(raw) - (ACC_W + 1)'(off_coef);
  wire signed [ACC_W+33:0] prod = diff * $signed({1'b0, gain_coef});
  wire signed [ACC_W+33:0] scaled = prod >>> `SDD_GAIN_SH;
  wire [23:0] sat = (scaled > $signed((ACC_W + 34)'(`SDD_RES_MAX))) ? `SDD_RES_MAX :
                    (scaled < -$signed((ACC_W + 34)'(`SDD_RES_MAX))) ? `SDD_RES_MIN :
                    scaled[23:0];
  wire load_res = res_v && settled && converting;
  wire self_cal = ctrl.cal_mode == `SDD_CALM_SELF || ctrl.cal_mode == `SDD_CALM_BG;
  wire [1:0] next_sel = !self_cal ? `SDD_SEL_NORMAL :
                        cal_state == sdd_pkg::CAL_ZERO ? `SDD_SEL_ZERO :
                        cal_state == sdd_pkg::CAL_FULL ? `SDD_SEL_FULL : `SDD_SEL_NORMAL;

  wire sdd_pkg::sdd_status_type status = '{cal_busy: !converting || cal_state == sdd_pkg::CAL_DIV,
                                           settled: settled, data_ready: data_ready};
  wire [31:0] rd_mux = (reg_addr == `SDD_ADDR_CTRL) ? 32'(ctrl) :
                       (reg_addr == `SDD_ADDR_DATA) ? {8'h00, result} :
                       (reg_addr == `SDD_ADDR_STATUS) ? 32'(status) :
                       (reg_addr == `SDD_ADDR_OFFSET) ? off_coef[31:0] :
                       (reg_addr == `SDD_ADDR_GAIN) ? gain_coef : 32'h0000_0000;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      result <= '0;
      data_ready <= 1'b0;
      reg_rdata <= '0;
      mod_strobe <= 1'b0;
      samp_strobe <= 1'b0;
      chan_sel <= 1'b0;
      gain_code <= 3'h0;
      cal_input_sel <= `SDD_SEL_NORMAL;
      standby_out <= 1'b0;
      result_strobe <= 1'b0;
    end else begin
      if (load_res) begin
        result <= sat;
      end
      // A new result in the same cycle as a data read keeps the flag set
      data_ready <= load_res || (data_ready && !rd_data);
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      mod_strobe <= mod_tick;
      samp_strobe <= samp_tick;
      chan_sel <= ctrl.chan;
      gain_code <= ctrl.gain;
      cal_input_sel <= next_sel;
      standby_out <= ctrl.standby;
      result_strobe <= load_res;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic [`SDD_CNT_W:0] since_mod;
  logic since_ok;
  always_ff @(posedge ref_clk) begin
    if (srst || standby_out || !since_ok && !mod_strobe) begin
      since_mod <= '0;
      since_ok <= !srst && !standby_out && mod_strobe;
    end else begin
      since_mod <= mod_strobe ? '0 : since_mod + 1'b1;
      since_ok <= 1'b1;
    end
  end

  property p_mod_period;
    @(posedge ref_clk) disable iff (srst)
      mod_strobe && since_ok && !$past(standby_out) |-> since_mod == `SDD_CNT_W'(`SDD_MOD_DIV - 1);
  endproperty
  a_mod_period: assert property (p_mod_period) else $error("modulator strobe spacing wrong");

  property p_samp_aligned;
    @(posedge ref_clk) disable iff (srst) mod_strobe |-> samp_strobe;
  endproperty
  a_samp_aligned: assert property (p_samp_aligned) else $error("sample strobe not aligned");

  property p_samp_cap;
    @(posedge ref_clk) disable iff (srst)
      samp_strobe && gain_code >= 3'h3 |=> !samp_strobe [*8];
  endproperty
  a_samp_cap: assert property (p_samp_cap) else $error("sample rate above cap");

  property p_standby_quiet;
    @(posedge ref_clk) disable iff (srst) standby_out |-> !mod_strobe && !samp_strobe;
  endproperty
  a_standby_quiet: assert property (p_standby_quiet) else $error("strobe in standby");

  property p_result_settled;
    @(posedge ref_clk) disable iff (srst) result_strobe |-> data_ready && $past(settled);
  endproperty
  a_result_settled: assert property (p_result_settled) else $error("unsettled result");

  property p_notch_default;
    @(posedge ref_clk) $past(srst) && !srst |-> ctrl.notch == `SDD_NOTCH_DEF;
  endproperty
  a_notch_default: assert property (p_notch_default) else $error("notch reset wrong");

  property p_cal_start;
    @(posedge ref_clk) disable iff (srst) cal_start |=> cal_state == sdd_pkg::CAL_ZERO;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration not started");

  property p_coef_write;
    @(posedge ref_clk) disable iff (srst) wr_gain |=> gain_coef == $past(reg_wdata);
  endproperty
  a_coef_write: assert property (p_coef_write) else $error("gain write lost");

  property p_background;
    @(posedge ref_clk) disable iff (srst)
      cal_state == sdd_pkg::CAL_DIV && div_n == '0 && ctrl.cal_mode == `SDD_CALM_BG && !cal_start
      |=> cal_state == sdd_pkg::CAL_GAP;
  endproperty
  a_background: assert property (p_background) else $error("background loop broken");

  property p_notch_range;
    @(posedge ref_clk) disable iff (srst)
      notch_eff >= `SDD_NOTCH_MIN && notch_eff <= `SDD_NOTCH_MAX;
  endproperty
  a_notch_range: assert property (p_notch_range) else $error("notch out of range");

endmodule // sdd_core

// [verilog/sdd_params.svh]
/*
  Constants for the sigma-delta decimation and control core: register map,
  control width and field codes, reset values and timing counts.
  Assumes a single master clock; included by bare name.
*/
`ifndef SDD_PARAMS_SVH
`define SDD_PARAMS_SVH

// ****************************************************************
// Clock division
// ****************************************************************
`define SDD_MOD_DIV 512
`define SDD_CNT_W 9
`define SDD_SAMP_DIV 256
`define SDD_SAMP_MAX_SH 3'h3

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define SDD_ADDR_W 5
`define SDD_ADDR_CTRL 5'h00
`define SDD_ADDR_DATA 5'h04
`define SDD_ADDR_STATUS 5'h08
`define SDD_ADDR_OFFSET 5'h0c
`define SDD_ADDR_GAIN 5'h10

// ****************************************************************
// Control fields and reset values
// ****************************************************************
`define SDD_CTRL_W 20
`define SDD_NOTCH_DEF 12'h145
`define SDD_NOTCH_MIN 12'h013
`define SDD_NOTCH_MAX 12'h7d0
`define SDD_CALM_NONE 3'h0
`define SDD_CALM_SELF 3'h1
`define SDD_CALM_SYS 3'h2
`define SDD_CALM_BG 3'h3
`define SDD_SEL_NORMAL 2'h0
`define SDD_SEL_ZERO 2'h1
`define SDD_SEL_FULL 2'h2

// ****************************************************************
// Filter, calibration and settling
// ****************************************************************
`define SDD_SETTLE_PERIODS 3'h4
`define SDD_GAIN_SH 22
`define SDD_GAIN_UNIT 32'h0040_0000
`define SDD_CAL_DIVIDEND 46'h1fff_ffc0_0000
`define SDD_DIV_STEPS 6'h2e
`define SDD_RES_MAX 24'h7f_ffff
`define SDD_RES_MIN 24'h80_0000

`endif

// [verilog/sdd_pkg.sv]
/*
  Types for the sigma-delta decimation and control core.
  Assumes sdd_params.svh supplies the numeric constants.
*/
package sdd_pkg;

  typedef struct packed {
    logic standby;
    logic [2:0] cal_mode;
    logic chan;
    logic [2:0] gain;
    logic [11:0] notch;
  } sdd_ctrl_type;

  typedef struct packed {
    logic cal_busy;
    logic settled;
    logic data_ready;
  } sdd_status_type;

  typedef enum logic [2:0] {
    CAL_IDLE,
    CAL_ZERO,
    CAL_FULL,
    CAL_DIV,
    CAL_GAP
  } sdd_cal_type;

endpackage

// [bench/sdd_mod_src.sv]
/*
  Behavioural modulator bit source standing in for the analog loop.
  Assumes it sits on the core's ref_clk and steps once per modulator strobe.
*/
`timescale 1ns/1ps

module sdd_mod_src (
  input wire logic ref_clk,
  input wire logic mod_strobe,
  input wire logic [1:0] mode,
  output logic mod_bit
);
  // ****************************************************************
  // Bit pattern
  // ****************************************************************
  // Mode 0 all zeros, 1 all ones, 2 half density (zero input)
  // Start in mode 0 or 1 so that the toggle of mode 2 begins from a known level
  always_ff @(posedge ref_clk) begin
    if (mode == 2'h2) begin
      if (mod_strobe) begin
        mod_bit <= ~mod_bit;
      end
    end else begin
      mod_bit <= mode[0];
    end
  end
endmodule // sdd_mod_src

// [bench/testbench.sv]
/*
  Self-checking bench for the decimation core: register port tasks,
  strobe timing per gain, output period and result value, calibration
  start and standby.
  Assumes sdd_params.svh and sdd_pkg are compiled before this file.
*/
`timescale 1ns/1ps
`include "sdd_params.svh"

module testbench;
  logic ref_clk;
  logic srst;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic mod_bit;
  logic mod_strobe;
  logic samp_strobe;
  logic chan_sel;
  logic [2:0] gain_code;
  logic [1:0] cal_input_sel;
  logic standby_out;
  logic result_strobe;
  logic [1:0] src_mode;
  int err_count;
  int total_checks;
  logic [31:0] rd_val;
  int per;
  int ns;
  sdd_pkg::sdd_ctrl_type ctrl;

  sdd_core sdd_core_inst (
    .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mod_bit_pin(mod_bit),
    .mod_strobe(mod_strobe), .samp_strobe(samp_strobe), .chan_sel(chan_sel),
    .gain_code(gain_code), .cal_input_sel(cal_input_sel), .standby_out(standby_out),
    .result_strobe(result_strobe)
  );

  sdd_mod_src sdd_mod_src_inst (
    .ref_clk(ref_clk), .mod_strobe(mod_strobe), .mode(src_mode), .mod_bit(mod_bit)
  );

  // ****************************************************************
  // Clock, reset and watchdog
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Run needs about 65k cycles; the limit leaves margin
  initial begin
    #380000;
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test();
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [4:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [4:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic read_check(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] d;
    reg_read(a, d);
    check(d, exp);
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Cycles from one modulator strobe to the next, and input samples inside
  task automatic mod_period(output int p, output int s);
    int n;
    n = 0;
    p = 0;
    #1;
    while (mod_strobe !== 1'b1 && n < 2000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    s = (samp_strobe === 1'b1) ? 1 : 0;
    do begin
      @(posedge ref_clk);
      #1;
      p++;
      if (mod_strobe !== 1'b1 && samp_strobe === 1'b1) s++;
    end while (mod_strobe !== 1'b1 && p < 2000);
  endtask

  task automatic wait_result(output int c);
    c = 0;
    do begin
      @(posedge ref_clk);
      #1;
      c++;
    end while (result_strobe !== 1'b1 && c < 60000);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    err_count = 0;
    total_checks = 0;
    srst = 1'b1;
    reg_addr = 5'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    src_mode = 2'h1;
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    // Reset values, unmapped and read-only places
    read_check(`SDD_ADDR_CTRL, 32'h0000_0145);
    read_check(`SDD_ADDR_GAIN, 32'h0040_0000);
    read_check(`SDD_ADDR_OFFSET, 32'h0000_0000);
    read_check(`SDD_ADDR_STATUS, 32'h0000_0000);
    reg_write(5'h14, 32'hffff_ffff);
    read_check(5'h14, 32'h0000_0000);
    reg_write(`SDD_ADDR_DATA, 32'h00ab_cdef);
    read_check(`SDD_ADDR_DATA, 32'h0000_0000);
    // Host coefficients written and read back
    reg_write(`SDD_ADDR_OFFSET, 32'h0000_0123);
    read_check(`SDD_ADDR_OFFSET, 32'h0000_0123);
    reg_write(`SDD_ADDR_GAIN, 32'h0080_0000);
    read_check(`SDD_ADDR_GAIN, 32'h0080_0000);
    reg_write(`SDD_ADDR_OFFSET, 32'h0000_0000);
    reg_write(`SDD_ADDR_GAIN, 32'h0040_0000);
    // Every gain code, channels alternating with gain: fixed modulator rate, capped sampling
    ctrl = '0;
    for (int g = 0; g < 8; g++) begin
      ctrl.notch = 12'h145;
      ctrl.gain = g[2:0];
      ctrl.chan = g[0];
      reg_write(`SDD_ADDR_CTRL, {12'h000, ctrl});
      mod_period(per, ns);
      mod_period(per, ns);
      check(gain_code, g[2:0]);
      check(chan_sel, g[0]);
      check(per, 512);
      // Gain zero already samples twice per modulator cycle: 512 over 256
      check(ns, (`SDD_MOD_DIV / `SDD_SAMP_DIV) << ((g > 3) ? 3 : g));
    end
    // Shortest notch, all-ones stream gives 19 cubed (0x1acb) at unit gain
    ctrl = '0;
    ctrl.notch = `SDD_NOTCH_MIN;
    reg_write(`SDD_ADDR_CTRL, {12'h000, ctrl});
    wait_result(per);
    check(per > 4 * 19 * 512, 1'b1);
    wait_result(per);
    check(per, 19 * 512);
    read_check(`SDD_ADDR_STATUS, 32'h0000_0003);
    read_check(`SDD_ADDR_DATA, 32'h0000_1acb);
    read_check(`SDD_ADDR_STATUS, 32'h0000_0002);
    // Calibration starts on a control write in each of the three calibration modes
    ctrl.cal_mode = `SDD_CALM_SELF;
    reg_write(`SDD_ADDR_CTRL, {12'h000, ctrl});
    wait_cycles(3);
    check(cal_input_sel, `SDD_SEL_ZERO);
    read_check(`SDD_ADDR_STATUS, 32'h0000_0004);
    ctrl.cal_mode = `SDD_CALM_SYS;
    reg_write(`SDD_ADDR_CTRL, {12'h000, ctrl});
    wait_cycles(3);
    check(cal_input_sel, `SDD_SEL_NORMAL);
    read_check(`SDD_ADDR_STATUS, 32'h0000_0004);
    ctrl.cal_mode = `SDD_CALM_BG;
    reg_write(`SDD_ADDR_CTRL, {12'h000, ctrl});
    wait_cycles(3);
    check(cal_input_sel, `SDD_SEL_ZERO);
    // Standby silences the strobes
    ctrl.cal_mode = `SDD_CALM_NONE;
    ctrl.standby = 1'b1;
    reg_write(`SDD_ADDR_CTRL, {12'h000, ctrl});
    wait_cycles(3);
    check(standby_out, 1'b1);
    mod_period(per, ns);
    check(per, 2000);
    check(result_strobe, 1'b0);
    end_of_test();
  end
endmodule // testbench
